// *** fts_counter.sv ***
`timescale 1ns/1ps
`include "hp_regs_consts.svh"
module fts_counter (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       start,
   input  wire logic [7:0] set_count,
   // Symbol stream
   output logic      [7:0] sym_r,
   output logic            sym_valid_r,
   output logic            done_r
);
   hp_regs_pkg::fts_state_t state_r;
   logic [7:0] sets_r;
   logic [1:0] fill_r;

   // One comma then three fillers per ordered set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r     <= hp_regs_pkg::FTS_IDLE;
         sets_r      <= 8'h00;
         fill_r      <= 2'h0;
         sym_r       <= 8'h00;
         sym_valid_r <= 1'b0;
         done_r      <= 1'b0;
      end else begin
         done_r      <= 1'b0;
         sym_valid_r <= 1'b0;
         case (state_r)
            hp_regs_pkg::FTS_IDLE: begin
               if (start && set_count != 8'h00) begin
                  sets_r  <= set_count;
                  state_r <= hp_regs_pkg::FTS_COMMA;
               end
            end
            hp_regs_pkg::FTS_COMMA: begin
               sym_r       <= `FTS_COMMA_K28_5;
               sym_valid_r <= 1'b1;
               fill_r      <= 2'(`FTS_SYMBOLS - 1);
               state_r     <= hp_regs_pkg::FTS_FILL;
            end
            hp_regs_pkg::FTS_FILL: begin
               sym_r       <= `FTS_FILL_K28_1;
               sym_valid_r <= 1'b1;
               fill_r      <= fill_r - 2'h1;
               if (fill_r == 2'h1) begin
                  sets_r <= sets_r - 8'h01;
                  if (sets_r == 8'h01) begin
                     done_r  <= 1'b1;
                     state_r <= hp_regs_pkg::FTS_IDLE;
                  end else begin
                     state_r <= hp_regs_pkg::FTS_COMMA;
                  end
               end
            end
            default: state_r <= hp_regs_pkg::FTS_IDLE;
         endcase
      end
   end
endmodule // fts_counter

// *** fts_sink.sv ***
`timescale 1ns/1ps
module fts_sink (
   // Clock, reset and clear
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clr,
   // Symbol stream
   input  wire logic [7:0] sym,
   input  wire logic       sym_valid,
   // Tally
   output logic      [7:0] sets,
   output logic            err
);
   logic [1:0] pos_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_r <= 2'd0;
         sets  <= 8'h00;
         err   <= 1'b0;
      end else if (clr) begin
         pos_r <= 2'd0;
         sets  <= 8'h00;
         err   <= 1'b0;
      end else if (sym_valid) begin
         // Comma opens each set, three fillers close it
         if (sym !== ((pos_r == 2'd0) ? 8'hbc : 8'h3c)) begin
            err <= 1'b1;
         end
         if (pos_r == 2'd3) begin
            sets <= sets + 8'h01;
         end
         pos_r <= pos_r + 2'd1;
      end
   end
endmodule // fts_sink

// *** hp_regs_consts.svh ***
`ifndef HP_REGS_CONSTS_SVH
`define HP_REGS_CONSTS_SVH

// Byte addresses
`define OFF_SLOT_CAPABILITY   8'hc4
`define OFF_SLOT_CTRL_STAT    8'hc8
`define OFF_LINK_TRAIN_CFG0   8'hcc
`define OFF_LINK_POWER_TMR    8'hd0
`define OFF_LINK_RECOV_LAT    8'hd4
`define OFF_IRQ_STATUS        8'he8
`define OFF_IRQ_MASK          8'hec

// Slot capability fields
`define CAP_ATTN_BUTTON       0
`define CAP_RETENTION_LATCH   2
`define CAP_ATTN_IND          3
`define CAP_PWR_IND           4
`define CAP_HP_CAPABLE        6

// Slot control / status layout
`define SC_EVT_EN_W           5
`define SC_HP_IRQ_EN          5
`define SC_WRITE_MASK         16'h07ff
`define SS_EVT_LSB            16
`define SS_LATCH_STATE        21
`define SS_PRESENCE_STATE     22

// Link training config 0
`define LT0_WRITE_MASK        32'hffff_1fff
`define LT0_RESET             32'h0400_1060
`define LT0_FORCE_CFG         3

// Link power timers
`define LPT_WRITE_MASK        32'hffff_03ff
`define LPT_RESET             32'h0400_0217

// Recovery and exit latency
`define LRL_WRITE_MASK        32'h007f_7fff
`define LRL_RESET             32'h0019_0254

// Fast training sequence symbols
`define FTS_COMMA_K28_5       8'hbc
`define FTS_FILL_K28_1        8'h3c
`define FTS_SYMBOLS           4

`endif

// *** hp_regs_pkg.sv ***
package hp_regs_pkg;
   typedef enum logic [1:0] {
      FTS_IDLE,
      FTS_COMMA,
      FTS_FILL
   } fts_state_t;
   typedef logic [31:0] word_t;
endpackage

// *** slot_event_catch.sv ***
`timescale 1ns/1ps
`include "hp_regs_consts.svh"
module slot_event_catch (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Events and clears
   input  wire logic [4:0] evt_in,
   input  wire logic [4:0] clr_in,
   input  wire logic [4:0] evt_en,
   input  wire logic       hp_irq_en,
   // Results
   output logic      [4:0] flags_r,
   output logic            hp_irq_r
);
   // Set wins over a same-cycle clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= 5'h0;
      end else begin
         flags_r <= (flags_r & ~clr_in) | evt_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hp_irq_r <= 1'b0;
      end else begin
         hp_irq_r <= hp_irq_en && |(flags_r & evt_en);
      end
   end
endmodule // slot_event_catch

// *** slot_hotplug_link_tuning_regs.sv ***
`timescale 1ns/1ps
`include "hp_regs_consts.svh"
module slot_hotplug_link_tuning_regs (
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Strap and slot inputs
   input  wire logic        hotplug_strap,
   input  wire logic [4:0]  slot_evt,
   input  wire logic        retention_latch_state,
   input  wire logic        presence_state,
   // Slot outputs
   output logic      [1:0]  attn_ind_ctrl,
   output logic      [1:0]  pwr_ind_ctrl,
   output logic             pwr_ctrl,
   // Training machine controls
   output logic             hot_reset_en,
   output logic             loopback_en,
   output logic             crosslink_en,
   output logic             force_config_state,
   output logic             debug_mode_sel,
   output logic      [2:0]  lane_neg_attempts,
   output logic      [4:0]  ts1_count,
   output logic      [15:0] l1_entry_timer,
   output logic      [9:0]  l0s_lifetime,
   output logic      [15:0] l1_lifetime,
   output logic      [6:0]  l0s_exit_latency,
   output logic      [6:0]  l1_exit_latency,
   // Fast training sequence stream
   input  wire logic        fts_start,
   output logic      [7:0]  fts_sym,
   output logic             fts_sym_valid,
   output logic             fts_done,
   // Interrupts
   output logic             hp_irq,
   output logic             irq
);
   logic        hp_en_r;
   logic [15:0] slot_ctrl_r;
   logic [31:0] cfg0_r;
   logic [31:0] tmr_r;
   logic [31:0] lat_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic [5:0]  irq_stat_r;
   logic [5:0]  irq_mask_r;
   logic        irq_r;
   logic [4:0]  slot_flags;
   logic [4:0]  slot_clr;
   logic        hp_irq_w;
   logic        hp_irq_d_r;
   logic        fts_done_w;
   logic [7:0]  fts_sym_w;
   logic        fts_valid_w;
   logic        setup;
   logic        wr_go;
   logic        known;

   function automatic logic [31:0] masked(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] mask);
      masked = (old_v & ~mask) | (new_v & mask);
   endfunction

   // Answer one cycle after setup, so no wait state
   assign setup = psel && !penable;
   assign wr_go = psel && penable && pready_r && pwrite;
   assign known = paddr == `OFF_SLOT_CAPABILITY || paddr == `OFF_SLOT_CTRL_STAT ||
                  paddr == `OFF_LINK_TRAIN_CFG0 || paddr == `OFF_LINK_POWER_TMR ||
                  paddr == `OFF_LINK_RECOV_LAT || paddr == `OFF_IRQ_STATUS ||
                  paddr == `OFF_IRQ_MASK;

   // Strap resampled every cycle after reset release; reset clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hp_en_r <= 1'b0;
      end else begin
         hp_en_r <= hotplug_strap;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_ctrl_r <= 16'h0000;
      end else if (wr_go && paddr == `OFF_SLOT_CTRL_STAT) begin
         slot_ctrl_r <= pwdata[15:0] & `SC_WRITE_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg0_r <= `LT0_RESET;
      end else if (wr_go && paddr == `OFF_LINK_TRAIN_CFG0) begin
         cfg0_r <= masked(cfg0_r, pwdata, `LT0_WRITE_MASK);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_r <= `LPT_RESET;
      end else if (wr_go && paddr == `OFF_LINK_POWER_TMR) begin
         tmr_r <= masked(tmr_r, pwdata, `LPT_WRITE_MASK);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_r <= `LRL_RESET;
      end else if (wr_go && paddr == `OFF_LINK_RECOV_LAT) begin
         lat_r <= masked(lat_r, pwdata, `LRL_WRITE_MASK);
      end
   end

   // Slot flags are read-only; the status word clears them too
   assign slot_clr = (wr_go && paddr == `OFF_IRQ_STATUS) ? pwdata[4:0] : 5'h00;

   slot_event_catch u_events (
      .pclk      (pclk),
      .presetn   (presetn),
      .evt_in    (slot_evt),
      .clr_in    (slot_clr),
      .evt_en    (slot_ctrl_r[`SC_EVT_EN_W-1:0]),
      .hp_irq_en (slot_ctrl_r[`SC_HP_IRQ_EN]),
      .flags_r   (slot_flags),
      .hp_irq_r  (hp_irq_w)
   );

   fts_counter u_fts (
      .pclk        (pclk),
      .presetn     (presetn),
      .start       (fts_start),
      .set_count   (lat_r[7:0]),
      .sym_r       (fts_sym_w),
      .sym_valid_r (fts_valid_w),
      .done_r      (fts_done_w)
   );

   // Sticky status: bits 4:0 slot events, bit 5 sequence done; set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= 6'h00;
      end else begin
         irq_stat_r <= (irq_stat_r & ~((wr_go && paddr == `OFF_IRQ_STATUS) ? pwdata[5:0] : 6'h00))
                       | {fts_done_w, slot_evt};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_r <= 6'h00;
      end else if (wr_go && paddr == `OFF_IRQ_MASK) begin
         irq_mask_r <= pwdata[5:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r      <= 1'b0;
         hp_irq_d_r <= 1'b0;
      end else begin
         irq_r      <= |(irq_stat_r & irq_mask_r);
         hp_irq_d_r <= hp_irq_w;
      end
   end

   // APB response
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup && !known;
         if (setup && !pwrite) begin
            case (paddr)
               `OFF_SLOT_CAPABILITY: begin
                  prdata_r <= 32'h0000_0000;
                  prdata_r[`CAP_ATTN_BUTTON]     <= hp_en_r;
                  prdata_r[`CAP_RETENTION_LATCH] <= hp_en_r;
                  prdata_r[`CAP_ATTN_IND]        <= hp_en_r;
                  prdata_r[`CAP_PWR_IND]         <= hp_en_r;
                  prdata_r[`CAP_HP_CAPABLE]      <= hp_en_r;
               end
               `OFF_SLOT_CTRL_STAT: begin
                  prdata_r <= {9'h000, presence_state, retention_latch_state,
                               slot_flags, slot_ctrl_r};
               end
               `OFF_LINK_TRAIN_CFG0: prdata_r <= cfg0_r;
               `OFF_LINK_POWER_TMR:  prdata_r <= tmr_r;
               `OFF_LINK_RECOV_LAT:  prdata_r <= lat_r;
               `OFF_IRQ_STATUS:      prdata_r <= {26'h000_0000, irq_stat_r};
               `OFF_IRQ_MASK:        prdata_r <= {26'h000_0000, irq_mask_r};
               default:              prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Registered copies so every output comes from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fts_sym       <= 8'h00;
         fts_sym_valid <= 1'b0;
         fts_done      <= 1'b0;
      end else begin
         fts_sym       <= fts_sym_w;
         fts_sym_valid <= fts_valid_w;
         fts_done      <= fts_done_w;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign irq     = irq_r;
   assign hp_irq  = hp_irq_d_r;

   assign attn_ind_ctrl      = slot_ctrl_r[7:6];
   assign pwr_ind_ctrl       = slot_ctrl_r[9:8];
   assign pwr_ctrl           = slot_ctrl_r[10];
   assign hot_reset_en       = cfg0_r[0];
   assign loopback_en        = cfg0_r[1];
   assign crosslink_en       = cfg0_r[2];
   assign force_config_state = cfg0_r[`LT0_FORCE_CFG];
   assign debug_mode_sel     = cfg0_r[4];
   assign lane_neg_attempts  = cfg0_r[7:5];
   assign ts1_count          = cfg0_r[12:8];
   assign l1_entry_timer     = cfg0_r[31:16];
   assign l0s_lifetime       = tmr_r[9:0];
   assign l1_lifetime        = tmr_r[31:16];
   assign l0s_exit_latency   = lat_r[14:8];
   assign l1_exit_latency    = lat_r[22:16];
endmodule // slot_hotplug_link_tuning_regs

// *** slot_hotplug_link_tuning_regs_asserts.sv ***
`timescale 1ns/1ps
module slot_hotplug_link_tuning_regs_asserts (
   // APB
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Slot and link
   input wire logic        hotplug_strap,
   input wire logic [1:0]  attn_ind_ctrl,
   input wire logic        pwr_ctrl,
   input wire logic [4:0]  ts1_count,
   input wire logic [15:0] l1_entry_timer,
   input wire logic [9:0]  l0s_lifetime,
   input wire logic [15:0] l1_lifetime,
   input wire logic [6:0]  l0s_exit_latency,
   input wire logic [6:0]  l1_exit_latency,
   input wire logic [7:0]  fts_sym,
   input wire logic        fts_sym_valid,
   input wire logic        hp_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_unmapped: assert property (pready |->
      pslverr == !(paddr inside {8'hc4, 8'hc8, 8'hcc, 8'hd0, 8'hd4, 8'he8, 8'hec}))
      else $error("pslverr wrong");
   a_cap_follows_strap: assert property (pready && !pwrite && paddr == 8'hc4 &&
      $stable(hotplug_strap) && $past(hotplug_strap, 2) == hotplug_strap |->
      prdata == (hotplug_strap ? 32'h0000_005d : 32'h0000_0000))
      else $error("capability read wrong");
   a_slot_ctrl_write: assert property (pready && pwrite && paddr == 8'hc8 |=>
      {pwr_ctrl, attn_ind_ctrl} == {$past(pwdata[10]), $past(pwdata[7:6])})
      else $error("slot control not written");
   a_cfg0_write: assert property (pready && pwrite && paddr == 8'hcc |=>
      {l1_entry_timer, ts1_count} == {$past(pwdata[31:16]), $past(pwdata[12:8])})
      else $error("config 0 not written");
   a_timer_write: assert property (pready && pwrite && paddr == 8'hd0 |=>
      {l1_lifetime, l0s_lifetime} == {$past(pwdata[31:16]), $past(pwdata[9:0])})
      else $error("lifetimes not written");
   a_latency_write: assert property (pready && pwrite && paddr == 8'hd4 |=>
      {l1_exit_latency, l0s_exit_latency} == {$past(pwdata[22:16]), $past(pwdata[14:8])})
      else $error("exit latencies not written");
   a_timer_hold: assert property (!(pready && pwrite) |=> $stable(l0s_lifetime) &&
      $stable(l1_lifetime))
      else $error("lifetime moved without write");
   a_fts_set_shape: assert property (fts_sym_valid && fts_sym == 8'hbc |=>
      (fts_sym_valid && fts_sym == 8'h3c) [*3])
      else $error("fast training set malformed");
   c_unmapped: cover property (pready && pslverr);
   c_hp_irq: cover property (hp_irq);
   c_fts_set: cover property (fts_sym_valid && fts_sym == 8'hbc);
endmodule // slot_hotplug_link_tuning_regs_asserts

bind slot_hotplug_link_tuning_regs slot_hotplug_link_tuning_regs_asserts chk_u (.*);

// *** test_slot_hotplug_link_tuning_regs.sv ***
`timescale 1ns/1ps
module test_slot_hotplug_link_tuning_regs;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, d;
   logic        pready, pslverr, er, err, clr = 1'b0, fts_start = 1'b0;
   logic        hotplug_strap = 1'b1, retention_latch_state, presence_state;
   logic [4:0]  slot_evt = 5'h00, e, ts1_count;
   logic [1:0]  attn_ind_ctrl, pwr_ind_ctrl;
   logic        pwr_ctrl, hot_reset_en, loopback_en, crosslink_en, force_config_state;
   logic        debug_mode_sel, fts_sym_valid, fts_done, hp_irq, irq;
   logic [2:0]  lane_neg_attempts;
   logic [15:0] l1_entry_timer, l1_lifetime;
   logic [9:0]  l0s_lifetime;
   logic [6:0]  l0s_exit_latency, l1_exit_latency;
   logic [7:0]  fts_sym, sets, a;
   logic [7:0]  ra [5] = '{8'hc4, 8'hc8, 8'hcc, 8'hd0, 8'hd4};
   logic [31:0] rv [5];
   int          failures = 0, comparisons = 0, k;

   always #50 pclk = ~pclk;

   slot_hotplug_link_tuning_regs dut_u (.*);
   fts_sink sink_u (.pclk, .presetn, .clr, .sym(fts_sym), .sym_valid(fts_sym_valid), .sets, .err);

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         failures++;
         $display("Error at %0t ns: got %h expected %h", $time, g, x);
      end
   endtask

   task automatic test_done;
      if (failures == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Request held until pready seen at an edge
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dv);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= dv;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         failures++;
         test_done();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic pulse_evt(input logic [4:0] ev);
      @(posedge pclk);
      slot_evt <= ev;
      @(posedge pclk);
      slot_evt <= 5'h00;
      repeat (4) @(posedge pclk);
   endtask

   function automatic logic [31:0] exp_rd(input logic [7:0] ad, input logic [31:0] dv);
      case (ad)
         8'hc8: return (dv & 32'h0000_07ff) | {9'h0, presence_state, retention_latch_state, 21'h0};
         8'hcc: return dv & 32'hffff_1fff;
         8'hd0: return dv & 32'hffff_03ff;
         8'hd4: return dv & 32'h007f_7fff;
         default: return 32'h0000_0000;
      endcase
   endfunction

   initial begin
      repeat (50000) @(posedge pclk);
      failures++;
      test_done();
   end

   initial begin
      void'($urandom(59880));
      retention_latch_state = 1'($urandom);
      presence_state = 1'($urandom);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk({lane_neg_attempts, ts1_count, l1_entry_timer}, 32'h0070_0400);
      chk({l0s_lifetime, l1_lifetime}, {6'h0, 10'h217, 16'h0400});
      chk({l0s_exit_latency, l1_exit_latency}, {18'h0, 7'h02, 7'h19});
      chk({hot_reset_en, loopback_en, crosslink_en, force_config_state, debug_mode_sel,
           attn_ind_ctrl, pwr_ind_ctrl, pwr_ctrl}, 32'h0);
      rv = '{32'h0000_005d, exp_rd(8'hc8, 0), 32'h0400_1060, 32'h0400_0217, 32'h0019_0254};
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, ra[i], 32'h0);
         chk(rd, rv[i]);
      end
      apb(1'b1, 8'hc4, 32'hffff_ffff);
      apb(1'b0, 8'hc4, 32'h0);
      chk(rd, 32'h0000_005d);
      apb(1'b1, 8'h10, $urandom);
      chk({31'h0, er}, 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      hotplug_strap <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(1'b0, 8'hc4, 32'h0);
      chk(rd, 32'h0);
      hotplug_strap <= 1'b1;
      // All-ones first, then random words
      for (int i = 0; i < 16; i++) begin
         a = ra[1 + i % 4];
         d = (i < 4) ? 32'hffff_ffff : $urandom;
         apb(1'b1, a, d);
         apb(1'b0, a, 32'h0);
         chk(rd, exp_rd(a, d));
         if (a == 8'hcc) chk({l1_entry_timer, 3'h0, ts1_count, lane_neg_attempts, debug_mode_sel,
            force_config_state, crosslink_en, loopback_en, hot_reset_en}, exp_rd(a, d));
         if (a == 8'hd0) chk({l1_lifetime, 6'h0, l0s_lifetime}, exp_rd(a, d));
         if (a == 8'hd4) chk({9'h0, l1_exit_latency, 1'b0, l0s_exit_latency, 8'h0},
            d & 32'h007f_7f00);
         if (a == 8'hc8) chk({21'h0, pwr_ctrl, pwr_ind_ctrl, attn_ind_ctrl, 6'h0},
            d & 32'h0000_07c0);
      end
      apb(1'b1, 8'hec, 32'h3f);
      apb(1'b1, 8'hc8, 32'h3f);
      for (int i = 0; i < 5; i++) begin
         e = 5'h1 << i;
         pulse_evt(e);
         chk({30'h0, hp_irq, irq}, 32'h3);
         apb(1'b0, 8'hc8, 32'h0);
         chk(rd, {9'h0, presence_state, retention_latch_state, e, 16'h003f});
         apb(1'b1, 8'he8, {27'h0, e});
         repeat (3) @(posedge pclk);
         chk({30'h0, hp_irq, irq}, 32'h0);
      end
      // Event enables off and mask closed: nothing may fire
      apb(1'b1, 8'hc8, 32'h20);
      apb(1'b1, 8'hec, 32'h0);
      pulse_evt(5'h1f);
      chk({30'h0, hp_irq, irq}, 32'h0);
      apb(1'b1, 8'hec, 32'h1f);
      repeat (3) @(posedge pclk);
      chk({30'h0, hp_irq, irq}, 32'h1);
      apb(1'b1, 8'he8, 32'h1f);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 8'hd4, 32'h0019_0200 | (i == 2 ? 32'h3 : i));
         @(posedge pclk);
         fts_start <= 1'b1;
         clr <= 1'b1;
         @(posedge pclk);
         fts_start <= 1'b0;
         clr <= 1'b0;
         k = 0;
         while (fts_done !== 1'b1 && k < 60) begin
            @(posedge pclk);
            k++;
         end
         // Sink counts the last set on this edge; read it once settled
         @(negedge pclk);
         chk({31'h0, k < 60}, {31'h0, i != 0});
         chk({23'h0, err, sets}, (i == 2) ? 32'h3 : i);
         apb(1'b0, 8'he8, 32'h0);
         chk(rd, (i == 0) ? 32'h0 : 32'h20);
         apb(1'b1, 8'he8, 32'h20);
      end
      test_done();
   end
endmodule // test_slot_hotplug_link_tuning_regs
